// >>> core/pcc_config_regs.v
/*
 configuration and clear-command registers of the pulse counter.
 assumes the modbus frontend and the counting logic share sys_clk;
 reg_wr and reg_rd are one-cycle strobes with a register index.
*/
`timescale 1ns/100ps
`include "pcc_map.vh"
module pcc_config_regs (
	sys_clk,
	sys_rst,
	reg_wr,
	reg_rd,
	reg_addr,
	reg_wdata,
	reg_rdata,
	reg_rvalid,
	op_mode,
	enc_count,
	cha_count,
	chb_count,
	enc_speed_in,
	clr_enc,
	clr_cha,
	clr_chb,
	ppr_cha,
	ppr_chb,
	ppr_enc,
	autosave_en,
	pullup_en,
	restart_req
);
	input sys_clk;
	input sys_rst;
	input reg_wr;
	input reg_rd;
	input [7:0] reg_addr;
	input [15:0] reg_wdata;
	output [15:0] reg_rdata;
	output reg_rvalid;
	input op_mode;
	input [31:0] enc_count;
	input [31:0] cha_count;
	input [31:0] chb_count;
	input [15:0] enc_speed_in;
	output clr_enc;
	output clr_cha;
	output clr_chb;
	output [15:0] ppr_cha;
	output [15:0] ppr_chb;
	output [15:0] ppr_enc;
	output autosave_en;
	output pullup_en;
	output restart_req;

	reg [15:0] ppr_cha_ff;
	reg [15:0] ppr_chb_ff;
	reg [15:0] ppr_enc_ff;
	reg [15:0] save_ff;
	reg [15:0] pullup_ff;
	reg [15:0] clear_ff;
	reg [15:0] restore_ff;
	reg clr_enc_ff;
	reg clr_cha_ff;
	reg clr_chb_ff;
	reg restart_ff;
	reg [15:0] rdata_ff;
	reg rvalid_ff;
	reg [15:0] nxt_rdata;
	reg nxt_clr_enc;
	reg nxt_clr_cha;
	reg nxt_clr_chb;
	wire wr_clear;
	wire do_restore;
	wire [31:0] enc_live;
	wire [31:0] cha_live;
	wire [31:0] chb_live;

	assign wr_clear = reg_wr && (reg_addr == `PCC_REG_CLEAR);
	assign do_restore = reg_wr && (reg_addr == `PCC_REG_RESTORE) &&
		(reg_wdata == `PCC_RESTORE_KEY);

	// a count with its clear pending reads zero, the counter zeroes next edge
	assign enc_live = clr_enc_ff ? `PCC_CNT_ZERO : enc_count;
	assign cha_live = clr_cha_ff ? `PCC_CNT_ZERO : cha_count;
	assign chb_live = clr_chb_ff ? `PCC_CNT_ZERO : chb_count;

	// clear code decode; undefined codes fire no strobe
	always @* begin
		nxt_clr_enc = 1'b0;
		nxt_clr_cha = 1'b0;
		nxt_clr_chb = 1'b0;
		if (wr_clear) begin
			if (reg_wdata == `PCC_CLR_ENC) begin
				nxt_clr_enc = 1'b1;
			end else if (reg_wdata == `PCC_CLR_CHA) begin
				nxt_clr_cha = 1'b1;
			end else if (reg_wdata == `PCC_CLR_CHB) begin
				nxt_clr_chb = 1'b1;
			end else if (reg_wdata == `PCC_CLR_BOTH) begin
				nxt_clr_cha = 1'b1;
				nxt_clr_chb = 1'b1;
			end
		end
	end

	// clear strobes, one cycle
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			clr_enc_ff <= 1'b0;
			clr_cha_ff <= 1'b0;
			clr_chb_ff <= 1'b0;
		end else begin
			clr_enc_ff <= nxt_clr_enc;
			clr_cha_ff <= nxt_clr_cha;
			clr_chb_ff <= nxt_clr_chb;
		end
	end

	// clear command holds the code one cycle, then self-returns to zero
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			clear_ff <= `PCC_RST_ZERO;
		end else if (wr_clear) begin
			clear_ff <= reg_wdata;
		end else begin
			clear_ff <= `PCC_RST_ZERO;
		end
	end

	// configuration registers, factory restore reloads defaults
	always @(posedge sys_clk) begin
		if (sys_rst || do_restore) begin
			ppr_cha_ff <= `PCC_RST_PPR_CH;
			ppr_chb_ff <= `PCC_RST_PPR_CH;
			ppr_enc_ff <= `PCC_RST_PPR_ENC;
			save_ff <= `PCC_RST_SAVE;
			pullup_ff <= `PCC_RST_PULLUP;
			restore_ff <= `PCC_RST_ZERO;
		end else if (reg_wr) begin
			if (reg_addr == `PCC_REG_PPR_A) begin
				ppr_cha_ff <= reg_wdata;
			end else if (reg_addr == `PCC_REG_PPR_B) begin
				ppr_chb_ff <= reg_wdata;
			end else if (reg_addr == `PCC_REG_PPR_ENC) begin
				ppr_enc_ff <= reg_wdata;
			end else if (reg_addr == `PCC_REG_SAVE) begin
				save_ff <= reg_wdata;
			end else if (reg_addr == `PCC_REG_PULLUP) begin
				pullup_ff <= reg_wdata;
			end else if (reg_addr == `PCC_REG_RESTORE) begin
				restore_ff <= reg_wdata;
			end
		end
	end

	// restart pulse in the same cycle that the restore loads the defaults
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			restart_ff <= 1'b0;
		end else begin
			restart_ff <= do_restore;
		end
	end

	// read mux; live counts read directly so clears show at once
	always @* begin
		nxt_rdata = `PCC_RST_ZERO;
		if (reg_addr == `PCC_REG_ENC_LO) begin
			nxt_rdata = enc_live[15:0];
		end else if (reg_addr == `PCC_REG_ENC_HI) begin
			nxt_rdata = enc_live[31:16];
		end else if (reg_addr == `PCC_REG_CHA_LO) begin
			nxt_rdata = cha_live[15:0];
		end else if (reg_addr == `PCC_REG_CHA_HI) begin
			nxt_rdata = cha_live[31:16];
		end else if (reg_addr == `PCC_REG_CHB_LO) begin
			nxt_rdata = chb_live[15:0];
		end else if (reg_addr == `PCC_REG_CHB_HI) begin
			nxt_rdata = chb_live[31:16];
		end else if (reg_addr == `PCC_REG_PPR_A) begin
			nxt_rdata = ppr_cha_ff;
		end else if (reg_addr == `PCC_REG_PPR_B) begin
			nxt_rdata = ppr_chb_ff;
		end else if (reg_addr == `PCC_REG_CLEAR) begin
			nxt_rdata = clear_ff;
		end else if (reg_addr == `PCC_REG_PPR_ENC) begin
			nxt_rdata = ppr_enc_ff;
		end else if (reg_addr == `PCC_REG_SAVE) begin
			nxt_rdata = save_ff;
		end else if (reg_addr == `PCC_REG_PULLUP) begin
			nxt_rdata = pullup_ff;
		end else if (reg_addr == `PCC_REG_RESTORE) begin
			nxt_rdata = restore_ff;
		end else if (reg_addr == `PCC_REG_ENC_SPEED) begin
			if (op_mode == `PCC_MODE_ENC) begin
				nxt_rdata = enc_speed_in;
			end
		end
	end

	always @(posedge sys_clk) begin
		if (sys_rst) begin
			rdata_ff <= `PCC_RST_ZERO;
			rvalid_ff <= 1'b0;
		end else begin
			rvalid_ff <= reg_rd;
			if (reg_rd) begin
				rdata_ff <= nxt_rdata;
			end
		end
	end

	assign reg_rdata = rdata_ff;
	assign reg_rvalid = rvalid_ff;
	assign clr_enc = clr_enc_ff;
	assign clr_cha = clr_cha_ff;
	assign clr_chb = clr_chb_ff;
	assign ppr_cha = ppr_cha_ff;
	assign ppr_chb = ppr_chb_ff;
	assign ppr_enc = ppr_enc_ff;
	assign autosave_en = save_ff[0];
	assign pullup_en = pullup_ff[0];
	assign restart_req = restart_ff;
endmodule

// >>> core/pcc_map.vh
/*
 holds register offsets, reset values and command codes of the pulse
 counter configuration bank; assumes a modbus frontend that delivers
 decoded 16-bit register reads and writes by register index.
*/
`ifndef PCC_MAP_VH
`define PCC_MAP_VH
`define PCC_REG_ENC_LO 8'h10
`define PCC_REG_ENC_HI 8'h11
`define PCC_REG_CHA_LO 8'h20
`define PCC_REG_CHA_HI 8'h21
`define PCC_REG_CHB_LO 8'h22
`define PCC_REG_CHB_HI 8'h23
`define PCC_REG_PPR_A 8'h28
`define PCC_REG_PPR_B 8'h29
`define PCC_REG_CLEAR 8'h43
`define PCC_REG_PPR_ENC 8'h48
`define PCC_REG_SAVE 8'h50
`define PCC_REG_PULLUP 8'h51
`define PCC_REG_RESTORE 8'h58
`define PCC_REG_ENC_SPEED 8'h64
`define PCC_RST_PPR_CH 16'h003C
`define PCC_RST_PPR_ENC 16'h03E8
`define PCC_RST_SAVE 16'h0001
`define PCC_RST_PULLUP 16'h0000
`define PCC_RST_ZERO 16'h0000
`define PCC_CNT_ZERO 32'h00000000
`define PCC_CLR_ENC 16'h000A
`define PCC_CLR_CHA 16'h0014
`define PCC_CLR_CHB 16'h0015
`define PCC_CLR_BOTH 16'h0016
`define PCC_RESTORE_KEY 16'hFF00
`define PCC_MODE_ENC 1'b0
`endif

// >>> tb/pcc_config_regs_monitor.sv
/* port checker of pcc_config_regs; one clock, bound onto it */
`timescale 1ns/100ps
module pcc_config_regs_monitor (input sys_clk, sys_rst, reg_wr, reg_rd,
	op_mode, reg_rvalid, input [7:0] reg_addr,
	input [15:0] reg_wdata, reg_rdata, ppr_enc,
	input clr_enc, clr_cha, clr_chb, autosave_en, pullup_en, restart_req);
	wire wc = reg_wr && reg_addr == 8'h43;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	property p_ce; wc&&reg_wdata==16'h000A |=> clr_enc&&!clr_cha; endproperty
	a_ce: assert property (p_ce) else $error("enc clear");
	property p_ca; wc&&reg_wdata==16'h0014 |=> clr_cha&&!clr_chb; endproperty
	a_ca: assert property (p_ca) else $error("a clear");
	property p_cb; wc&&reg_wdata==16'h0016 |=> clr_cha&&clr_chb; endproperty
	a_cb: assert property (p_cb) else $error("ab clear");
	property p_cbb; wc&&reg_wdata==16'h0015 |=> clr_chb&&!clr_cha; endproperty
	a_cbb: assert property (p_cbb) else $error("b clear");
	property p_cx; clr_cha||clr_chb |-> $past(wc&&(reg_wdata==16'h0014||
		reg_wdata==16'h0015||reg_wdata==16'h0016)); endproperty
	a_cx: assert property (p_cx) else $error("stray ch clear");
	property p_sp; reg_rd&&reg_addr==8'h64&&op_mode
		|=> reg_rvalid&&reg_rdata==16'h0000; endproperty
	a_sp: assert property (p_sp) else $error("speed mode");
	property p_c12; wc&&reg_wdata==16'h000A ##1 reg_rd&&reg_addr==8'h10
		|=> reg_rdata==16'h0000; endproperty
	a_c12: assert property (p_c12) else $error("clear read");
	property p_cn; clr_enc |-> $past(wc&&reg_wdata==16'h000A); endproperty
	a_cn: assert property (p_cn) else $error("stray clear");
	property p_rs; reg_wr&&reg_addr==8'h58&&reg_wdata==16'hFF00
		|=> restart_req&&ppr_enc==16'h03E8 ##1 !restart_req; endproperty
	a_rs: assert property (p_rs) else $error("restore");
	property p_pe; reg_wr&&reg_addr==8'h48 |=> ppr_enc==$past(reg_wdata);
	endproperty
	a_pe: assert property (p_pe) else $error("enc ppr");
	property p_sv; reg_wr&&reg_addr==8'h50 |=> autosave_en==$past(reg_wdata[0]);
	endproperty
	a_sv: assert property (p_sv) else $error("autosave");
	property p_pu; reg_wr&&reg_addr==8'h51 |=> pullup_en==$past(reg_wdata[0]);
	endproperty
	a_pu: assert property (p_pu) else $error("pullup");
	c_ce: cover property (clr_enc);
	c_cb: cover property (clr_cha && clr_chb);
	c_rs: cover property (restart_req);
endmodule
bind pcc_config_regs pcc_config_regs_monitor mon_u (.*);

// >>> tb/pcc_cnt_model.sv
/* counting logic stand-in; counts pulse, zeroed by clear pulses */
`timescale 1ns/100ps
module pcc_cnt_model (input sys_clk, sys_rst, pulse, clr_enc, clr_cha,
	clr_chb, output [31:0] enc_count, cha_count, chb_count);
	reg [31:0] enc_ff, cha_ff, chb_ff;
	always @(posedge sys_clk) begin
		enc_ff <= sys_rst | clr_enc ? 32'h0 : enc_ff + 32'(pulse);
		cha_ff <= sys_rst | clr_cha ? 32'h0 : cha_ff + 32'(pulse);
		chb_ff <= sys_rst | clr_chb ? 32'h0 : chb_ff + 32'(pulse);
	end
	assign {enc_count, cha_count, chb_count} = {enc_ff, cha_ff, chb_ff};
endmodule

// >>> tb/pcc_config_regs_tb.sv
/* bench of pcc_config_regs; the counting model feeds live counts */
`timescale 1ns/100ps
module pcc_config_regs_tb;
	logic sys_clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, op_mode = 0;
	logic pulse = 0;
	logic [7:0] reg_addr = 8'h00;
	logic [15:0] reg_wdata = 16'h0000, enc_speed_in = 16'h1234;
	wire [15:0] reg_rdata, ppr_cha, ppr_chb, ppr_enc;
	wire [31:0] enc_count, cha_count, chb_count;
	wire reg_rvalid, clr_enc, clr_cha, clr_chb, autosave_en, pullup_en;
	wire restart_req;
	int err_total = 0, comparisons = 0;
	pcc_config_regs dut_u (.*);
	pcc_cnt_model cnt_u (.*);
	initial forever #25 sys_clk = ~sys_clk;
	task chk(input [15:0] g, e);
		comparisons++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %0t got %h want %h", $time, g, e);
		end
	endtask
	task bus(input w, input [7:0] a, input [15:0] d);
		@(posedge sys_clk);
		{reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, d};
		@(posedge sys_clk);
		{reg_wr, reg_rd} <= 2'b00;
		#1 if (!w) chk(reg_rvalid ? reg_rdata : 16'hBAD0, d);
	endtask
	task t_dflt;
		bus(0,8'h28,16'h003C);
		bus(0,8'h29,16'h003C);
		chk(ppr_cha, 16'h003C);
		chk(ppr_chb, 16'h003C);
		bus(0,8'h48,16'h03E8);
		bus(0,8'h50,16'h0001);
		bus(0,8'h51,16'h0000);
		bus(0,8'h64,16'h1234);
		@(posedge sys_clk);
		op_mode <= 1;
		bus(0,8'h64,16'h0000);
	endtask
	task t_clr;
		@(posedge sys_clk);
		pulse <= 1;
		repeat (5) @(posedge sys_clk);
		pulse <= 0;
		bus(1,8'h43,16'h000B);
		bus(0,8'h10,16'h0005);
		bus(0,8'h11,16'h0000);
		bus(0,8'h20,16'h0005);
		bus(0,8'h22,16'h0005);
		bus(1,8'h43,16'h000A);
		bus(0,8'h10,16'h0000);
		bus(0,8'h20,16'h0005);
		bus(1,8'h43,16'h0014);
		bus(0,8'h20,16'h0000);
		bus(0,8'h22,16'h0005);
		bus(1,8'h43,16'h0015);
		bus(0,8'h22,16'h0000);
		bus(0,8'h43,16'h0000);
		@(posedge sys_clk);
		pulse <= 1;
		repeat (3) @(posedge sys_clk);
		pulse <= 0;
		bus(1,8'h43,16'h0016);
		bus(0,8'h20,16'h0000);
		bus(0,8'h22,16'h0000);
		bus(0,8'h10,16'h0003);
		bus(0,8'h43,16'h0000);
	endtask
	task t_cfg;
		bus(1,8'h28,16'h0064);
		bus(1,8'h29,16'h00C8);
		bus(1,8'h48,16'h07D0);
		bus(1,8'h50,16'h0000);
		bus(1,8'h51,16'h0001);
		bus(1,8'h58,16'h1234);
		bus(0,8'h28,16'h0064);
		bus(0,8'h29,16'h00C8);
		chk(ppr_chb, 16'h00C8);
		bus(0,8'h48,16'h07D0);
		bus(0,8'h50,16'h0000);
		bus(0,8'h51,16'h0001);
		bus(0,8'h58,16'h1234);
		chk({15'h0, autosave_en}, 16'h0000);
		chk({15'h0, pullup_en}, 16'h0001);
		chk({15'h0, restart_req}, 16'h0000);
		bus(1,8'h58,16'hFF00);
		chk({15'h0, restart_req}, 16'h0001);
		chk(ppr_enc, 16'h03E8);
		@(posedge sys_clk);
		#1 chk({15'h0, restart_req}, 16'h0000);
		bus(0,8'h28,16'h003C);
		bus(0,8'h50,16'h0001);
		bus(0,8'h51,16'h0000);
		bus(0,8'h58,16'h0000);
	endtask
	task t_b2b;
		@(posedge sys_clk);
		pulse <= 1;
		@(posedge sys_clk);
		{pulse, reg_wr, reg_addr, reg_wdata} <= {2'b01, 8'h43, 16'h000A};
		@(posedge sys_clk);
		{reg_wr, reg_rd, reg_addr} <= {2'b01, 8'h10};
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rvalid ? reg_rdata : 16'hBAD0, 16'h0000);
	endtask
	task t_rst;
		bus(1,8'h48,16'h0BB8);
		@(posedge sys_clk);
		sys_rst <= 1;
		repeat (2) @(posedge sys_clk);
		sys_rst <= 0;
		bus(0,8'h48,16'h03E8);
		bus(0,8'h50,16'h0001);
	endtask
	task summarize;
		$display("errors %0d checks %0d", err_total, comparisons);
		if (err_total == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge sys_clk);
		sys_rst <= 0;
		t_dflt;
		t_clr;
		t_cfg;
		t_b2b;
		t_rst;
		summarize;
	end
	initial begin
		#100000 err_total++;
		summarize;
	end
endmodule
